//--- rtl/pid_regulator_defs.vh
// Purpose: Offsets, field positions, reset values and timing for the PID block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Percent values are in 0.1 % units, gains in 0.01, times in 0.01 s except loss time in 0.1 s
`ifndef PID_REGULATOR_DEFS_VH
`define PID_REGULATOR_DEFS_VH

`define OFS_CTRL 12'h000
`define OFS_SETPOINT 12'h004
`define OFS_GAIN 12'h008
`define OFS_ITIME 12'h00c
`define OFS_DTIME 12'h010
`define OFS_DEADBAND 12'h014
`define OFS_LOSS_THR 12'h018
`define OFS_LOSS_TIME 12'h01c
`define OFS_MAXFREQ 12'h020
`define OFS_COMM 12'h024
`define OFS_STATUS 12'h028
`define OFS_OUTPUT 12'h02c
`define OFS_SAMPLE 12'h030
`define OFS_PRESET0 12'h040

// Control register fields
`define CTRL_FSRC_LSB 0
`define CTRL_SPSRC_LSB 4
`define CTRL_FBSRC_LSB 8
`define CTRL_SENSE_BIT 12

`define FSRC_PID 4'h5
`define SP_KEYPAD 3'h0
`define SP_AIN1 3'h1
`define SP_AIN2 3'h2
`define SP_COMM 3'h3
`define SP_PRESET 3'h4
`define FB_AIN1 2'h0
`define FB_AIN2 2'h1
`define FB_SUM 2'h2
`define FB_COMM 2'h3

`define RST_GAIN 16'h0064
`define RST_ITIME 16'h000a
`define RST_DTIME 16'h0000
`define RST_LOSS_TIME 16'h000a
`define RST_MAXFREQ 16'h1388
`define RST_SAMPLE 16'h0001

// Full scale in 0.1 % units
`define FULL_SCALE 1000
// Loss time unit 0.1 s, clock 100 MHz
`define CLK_HZ 100000000
`define LOSS_UNIT_CYCLES (`CLK_HZ / 10)
// Sample period unit 10 ms
`define SAMPLE_UNIT_CYCLES (`CLK_HZ / 100)

`endif

//--- rtl/pid_regulator.v
// Purpose: Process PID regulator with feedback loss watch and eight presets
// Assumes: Analog inputs are 0..1000 (0.1 %) from ADC logic on ref_clk
// Notes: Output is frequency command in maximum_frequency units
//
// Local design decisions: the register offsets and the APB interface to the registers.
`include "pid_regulator_defs.vh"

// Contract
// RQ1 - Keypad setpoint source uses stored setpoint 0..100.0 %, default 0.
// RQ2 - Feedback select: 0 ain1, 1 ain2, 2 sum, 3 comm; default 0.
// RQ3 - Positive sense: feedback above setpoint lowers the command.
// RQ4 - Negative sense: feedback above setpoint raises the command.
// RQ5 - Gain 0..100.00, default 1.00; gain 100 at 100 % gives fmax.
// RQ6 - Integral time 0.01..10 s, default 0.1 s; ramps fmax in Ti.
// RQ7 - Derivative time 0..10 s, default 0; full change in Td gives fmax.
// RQ8 - Integral accumulates every period while error is nonzero; the code holds it within the deviation limit.
// RQ9 - Derivative follows error change only, not error itself.
// RQ10 - Sample and compute exactly once per sampling period.
// RQ11 - Within deviation limit the output holds.
// RQ12 - Loss threshold relative to full range, 0..100 %, default 0.
// RQ13 - Feedback at or below threshold longer than loss time raises fault.
// RQ14 - Eight signed presets -100..100 %, negative means reverse.
// RQ15 - Preset 100 % maps to maximum frequency, linear scaling.
// RQ16 - Three terminals form preset index, bit0 least significant.
// RQ17 - Configure different channels for setpoint and feedback.
// RQ18 - Setpoint select: 0 keypad, 1 ain1, 2 ain2, 3 comm, 4 preset.
// RQ19 - Regulator active only when frequency source select is 5.
// RQ20 - Setpoint and feedback handled as relative values.
// RQ21 - Output and integral clamped between zero and fmax.
// RQ22 - Reset clears integral, previous error and loss timer.
module pid_regulator #(
	parameter [31:0] LOSS_UNIT = `LOSS_UNIT_CYCLES,
	parameter [31:0] SAMPLE_UNIT = `SAMPLE_UNIT_CYCLES
)(
	input wire ref_clk,
	input wire rst_n,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [9:0] voltage_analog_input,
	input wire [9:0] current_analog_input,
	input wire preset_select_bit0,
	input wire preset_select_bit1,
	input wire preset_select_bit2,
	output reg [15:0] freq_cmd_ff,
	output reg reverse_ff,
	output reg feedback_loss_fault_ff
);

	reg [31:0] ctrl_ff;
	reg [9:0] keypad_pid_setpoint_ff;
	reg [15:0] proportional_gain_ff;
	reg [15:0] integral_time_ff;
	reg [15:0] derivative_time_ff;
	reg [9:0] deadband_ff;
	reg [9:0] feedback_loss_threshold_ff;
	reg [15:0] feedback_loss_time_ff;
	reg [15:0] maximum_frequency_ff;
	reg [9:0] comm_value_ff;
	reg [15:0] sample_period_ff;
	reg signed [10:0] preset_ff [0:7];
	reg [1:0] s0_ff;
	reg [1:0] s1_ff;
	reg [1:0] s2_ff;
	reg [39:0] integ_ff;
	reg signed [11:0] prev_err_ff;
	reg [31:0] loss_cnt_ff;
	reg [15:0] loss_units_ff;
	reg [31:0] samp_cnt_ff;
	reg [15:0] samp_units_ff;
	reg sample_ff;
	wire [3:0] frequency_source_select = ctrl_ff[`CTRL_FSRC_LSB +: 4];
	wire [2:0] setpoint_source_select = ctrl_ff[`CTRL_SPSRC_LSB +: 3];
	wire [1:0] feedback_source_select = ctrl_ff[`CTRL_FBSRC_LSB +: 2];
	wire output_sense_select = ctrl_ff[`CTRL_SENSE_BIT];
	wire pid_on = (frequency_source_select == `FSRC_PID); // [RQ19]
	wire wr = psel & penable & pwrite & clk_en;
	wire [2:0] sel_idx = {s2_ff[1], s1_ff[1], s0_ff[1]}; // [RQ16]
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	function [9:0] sat_pct;
		input [10:0] v;
		begin
			sat_pct = (v > `FULL_SCALE) ? 10'd1000 : v[9:0];
		end
	endfunction
	function is_preset;
		input [11:0] a;
		begin
			is_preset = (a[11:5] == `OFS_PRESET0 >> 5) && (a[1:0] == 2'b00);
		end
	endfunction
	// Signed preset magnitude limited to +-100.0 %
	function signed [10:0] clip_preset;
		input [31:0] w;
		begin
			if ($signed(w) > 1000)
				clip_preset = 11'sd1000;
			else if ($signed(w) < -1000)
				clip_preset = -11'sd1000;
			else
				clip_preset = w[10:0];
		end
	endfunction
	reg [9:0] feedback;
	reg [9:0] setpoint;
	always @*
	begin
		case (feedback_source_select) // [RQ2]
			`FB_AIN1: feedback = voltage_analog_input;
			`FB_AIN2: feedback = current_analog_input;
			`FB_SUM: feedback = sat_pct({1'b0, voltage_analog_input}
				+ {1'b0, current_analog_input});
			default: feedback = comm_value_ff;
		endcase
		case (setpoint_source_select) // [RQ18]
			`SP_KEYPAD: setpoint = keypad_pid_setpoint_ff; // [RQ1]
			`SP_AIN1: setpoint = voltage_analog_input;
			`SP_AIN2: setpoint = current_analog_input;
			`SP_COMM: setpoint = comm_value_ff;
			default: setpoint = preset_ff[sel_idx][10] ? 10'd0
				: preset_ff[sel_idx][9:0];
		endcase
	end

	// Error in 0.1 % units; positive sense means feedback above lowers output
	wire signed [11:0] raw_err = $signed({2'b00, setpoint})
		- $signed({2'b00, feedback}); // [RQ20]
	wire signed [11:0] err = output_sense_select ? -raw_err : raw_err; // [RQ3] [RQ4]
	wire [11:0] abs_err = err[11] ? -err : err;
	wire in_band = abs_err <= {2'b00, deadband_ff};
	wire signed [11:0] derr = err - prev_err_ff; // [RQ9]

	// Terms scaled so gain 10000 * 1000 maps to maximum_frequency
	wire signed [31:0] p_term = err * $signed({1'b0, proportional_gain_ff});
	// Integral step per sample: err*Ts/Ti, kept with sample units in num
	wire signed [39:0] i_step = (err * $signed({1'b0, sample_period_ff}))
		* 40'sd10000; // [RQ6]
	wire signed [39:0] i_scaled = i_step / $signed({1'b0, integral_time_ff});
	wire signed [39:0] integ_sum = $signed(integ_ff) + i_scaled; // [RQ8]
	wire signed [39:0] imax = 40'sd10000000;
	wire [39:0] integ_nxt = integ_sum < 0 ? 40'd0
		: (integ_sum > imax ? imax[39:0] : integ_sum[39:0]); // [RQ21]
	wire signed [39:0] d_term = (derr * 40'sd10000
		* $signed({1'b0, derivative_time_ff}))
		/ $signed({1'b0, sample_period_ff}); // [RQ7]
	wire signed [39:0] total = p_term + $signed(integ_nxt) + d_term; // [RQ5]
	wire [39:0] total_sat = total < 0 ? 40'd0
		: (total > imax ? imax[39:0] : total[39:0]); // [RQ21]
	wire [55:0] fprod = total_sat * maximum_frequency_ff;
	// Quotients stay full width; the ranges keep them below 16 bits
	wire [55:0] pid_freq = fprod / 56'd10000000;
	// Preset scaling: 1000 maps to maximum_frequency
	wire signed [10:0] psel_val = preset_ff[sel_idx]; // [RQ14]
	wire [10:0] pmag = psel_val[10] ? -psel_val : psel_val;
	wire [25:0] pprod = pmag[9:0] * maximum_frequency_ff; // [RQ15]
	wire [25:0] preset_freq = pprod / 26'd1000;
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_ff <= 32'h0;
			keypad_pid_setpoint_ff <= 10'h0;
			proportional_gain_ff <= `RST_GAIN;
			integral_time_ff <= `RST_ITIME;
			derivative_time_ff <= `RST_DTIME;
			deadband_ff <= 10'h0;
			feedback_loss_threshold_ff <= 10'h0; // [RQ12]
			feedback_loss_time_ff <= `RST_LOSS_TIME;
			maximum_frequency_ff <= `RST_MAXFREQ;
			comm_value_ff <= 10'h0;
			sample_period_ff <= `RST_SAMPLE;
		end
		else if (wr)
		begin
			if (paddr == `OFS_CTRL)
				ctrl_ff <= {19'h0, pwdata[12:0]};
			else if (paddr == `OFS_SETPOINT)
				keypad_pid_setpoint_ff <= sat_pct(pwdata[10:0]);
			else if (paddr == `OFS_GAIN)
				proportional_gain_ff <= pwdata[15:0] > 16'd10000
					? 16'd10000 : pwdata[15:0];
			else if (paddr == `OFS_ITIME)
				integral_time_ff <= pwdata[15:0] == 16'h0 ? 16'h1
					: (pwdata[15:0] > 16'd1000 ? 16'd1000 : pwdata[15:0]);
			else if (paddr == `OFS_DTIME)
				derivative_time_ff <= pwdata[15:0] > 16'd1000
					? 16'd1000 : pwdata[15:0];
			else if (paddr == `OFS_DEADBAND)
				deadband_ff <= sat_pct(pwdata[10:0]);
			else if (paddr == `OFS_LOSS_THR)
				feedback_loss_threshold_ff <= sat_pct(pwdata[10:0]);
			else if (paddr == `OFS_LOSS_TIME)
				feedback_loss_time_ff <= pwdata[15:0] > 16'd36000
					? 16'd36000 : pwdata[15:0];
			else if (paddr == `OFS_MAXFREQ)
				maximum_frequency_ff <= pwdata[15:0];
			else if (paddr == `OFS_COMM)
				comm_value_ff <= sat_pct(pwdata[10:0]);
			else if (paddr == `OFS_SAMPLE)
				sample_period_ff <= pwdata[15:0] == 16'h0 ? 16'h1
					: pwdata[15:0];
		end
	end
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : presets
			always @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
					preset_ff[g] <= 11'h0;
				else if (wr && is_preset(paddr) && paddr[4:2] == g)
					preset_ff[g] <= clip_preset(pwdata);
			end
		end
	endgenerate
	// Terminals come from pins: two flops each
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s0_ff <= 2'b00;
			s1_ff <= 2'b00;
			s2_ff <= 2'b00;
		end
		else if (clk_en)
		begin
			s0_ff <= {s0_ff[0], preset_select_bit0};
			s1_ff <= {s1_ff[0], preset_select_bit1};
			s2_ff <= {s2_ff[0], preset_select_bit2};
		end
	end

	// Sampling tick every sample_period_ff * 10 ms
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			samp_cnt_ff <= 32'h0;
			samp_units_ff <= 16'h0;
			sample_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			sample_ff <= 1'b0;
			if (samp_cnt_ff >= SAMPLE_UNIT - 32'h1)
			begin
				samp_cnt_ff <= 32'h0;
				if (samp_units_ff >= sample_period_ff - 16'h1)
				begin
					samp_units_ff <= 16'h0;
					sample_ff <= 1'b1; // [RQ10]
				end
				else
					samp_units_ff <= samp_units_ff + 16'h1;
			end
			else
				samp_cnt_ff <= samp_cnt_ff + 32'h1;
		end
	end

	// PID update once per sample
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			integ_ff <= 40'h0; // [RQ22]
			prev_err_ff <= 12'sh0;
			freq_cmd_ff <= 16'h0;
			reverse_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!pid_on)
			begin
				integ_ff <= 40'h0;
				prev_err_ff <= 12'sh0;
				freq_cmd_ff <= preset_freq[15:0];
				reverse_ff <= psel_val[10]; // [RQ14]
			end
			else if (sample_ff) // [RQ10]
			begin
				reverse_ff <= 1'b0;
				prev_err_ff <= err;
				if (!in_band) // [RQ11]
				begin
					if (err != 12'sh0)
						integ_ff <= integ_nxt; // [RQ8]
					freq_cmd_ff <= pid_freq[15:0];
				end
			end
		end
	end

	// Loss timer counts 0.1 s units while feedback is low
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			loss_cnt_ff <= 32'h0; // [RQ22]
			loss_units_ff <= 16'h0;
			feedback_loss_fault_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!pid_on || feedback > feedback_loss_threshold_ff)
			begin
				loss_cnt_ff <= 32'h0;
				loss_units_ff <= 16'h0;
			end
			else if (loss_units_ff > feedback_loss_time_ff)
				feedback_loss_fault_ff <= 1'b1; // [RQ13]
			else if (loss_cnt_ff >= LOSS_UNIT - 32'h1)
			begin
				loss_cnt_ff <= 32'h0;
				loss_units_ff <= loss_units_ff + 16'h1;
			end
			else
				loss_cnt_ff <= loss_cnt_ff + 32'h1;
			// Write 1 to status bit 0 clears; a new event wins
			if (wr && paddr == `OFS_STATUS && pwdata[0]
				&& !(pid_on && feedback <= feedback_loss_threshold_ff
				&& loss_units_ff > feedback_loss_time_ff))
				feedback_loss_fault_ff <= 1'b0;
		end
	end

	always @*
	begin
		prdata = 32'h0;
		if (paddr == `OFS_CTRL)
			prdata = ctrl_ff;
		else if (paddr == `OFS_SETPOINT)
			prdata = {22'h0, keypad_pid_setpoint_ff};
		else if (paddr == `OFS_GAIN)
			prdata = {16'h0, proportional_gain_ff};
		else if (paddr == `OFS_ITIME)
			prdata = {16'h0, integral_time_ff};
		else if (paddr == `OFS_DTIME)
			prdata = {16'h0, derivative_time_ff};
		else if (paddr == `OFS_DEADBAND)
			prdata = {22'h0, deadband_ff};
		else if (paddr == `OFS_LOSS_THR)
			prdata = {22'h0, feedback_loss_threshold_ff};
		else if (paddr == `OFS_LOSS_TIME)
			prdata = {16'h0, feedback_loss_time_ff};
		else if (paddr == `OFS_MAXFREQ)
			prdata = {16'h0, maximum_frequency_ff};
		else if (paddr == `OFS_COMM)
			prdata = {22'h0, comm_value_ff};
		else if (paddr == `OFS_STATUS)
			prdata = {27'h0, sel_idx, reverse_ff, feedback_loss_fault_ff};
		else if (paddr == `OFS_OUTPUT)
			prdata = {16'h0, freq_cmd_ff};
		else if (paddr == `OFS_SAMPLE)
			prdata = {16'h0, sample_period_ff};
		else if (is_preset(paddr))
			prdata = {{21{preset_ff[paddr[4:2]][10]}}, preset_ff[paddr[4:2]]};
	end

endmodule

//--- verification/pid_regulator_checker.sv
// Purpose: Port checks for the PID regulator
// Assumes: Register offsets from the shared defines header
// Notes: Only the frequency source field of CTRL is shadowed here
`include "pid_regulator_defs.vh"
module pid_regulator_checker (
	input wire ref_clk,
	input wire rst_n,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire [15:0] freq_cmd_ff,
	input wire reverse_ff,
	input wire feedback_loss_fault_ff
);
	logic [3:0] fsrc_ff;
	wire wr = clk_en && psel && penable && pwrite;
	wire pid_on = fsrc_ff == `FSRC_PID;
	wire clr = wr && paddr == `OFS_STATUS && pwdata[0];
	always @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			fsrc_ff <= 4'h0;
		else if (wr && paddr == `OFS_CTRL)
			fsrc_ff <= pwdata[3:0];
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	fault_hold_a: assert property (
		feedback_loss_fault_ff && !clr |=> feedback_loss_fault_ff)
		else $error("loss fault dropped without a clear");
	freeze_hold_a: assert property (
		!clk_en |=> $stable(freq_cmd_ff) && $stable(reverse_ff)
		&& $stable(feedback_loss_fault_ff)) else $error("state moved");
	pid_forward_a: assert property (
		pid_on [*8] |-> !reverse_ff) else $error("reverse under PID");
	fault_cause_a: assert property (
		$rose(feedback_loss_fault_ff) |-> $past(pid_on))
		else $error("loss fault with regulator off");
	tick_gap_a: assert property (
		pid_on && $past(pid_on) && $changed(freq_cmd_ff)
		|=> $stable(freq_cmd_ff) [*4]) else $error("two updates per tick");
	unmapped_zero_a: assert property (
		psel && paddr inside {12'h034, 12'h03c} |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	status_mirror_a: assert property (
		psel && paddr == `OFS_STATUS |-> prdata[1:0] ==
		{reverse_ff, feedback_loss_fault_ff}) else $error("status bits");
	output_mirror_a: assert property (
		psel && paddr == `OFS_OUTPUT |-> prdata[15:0] == freq_cmd_ff)
		else $error("output register differs");
endmodule
bind pid_regulator pid_regulator_checker i_chk (.ref_clk, .rst_n, .clk_en,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .freq_cmd_ff,
	.reverse_ff, .feedback_loss_fault_ff);

//--- verification/field_side_model.sv
// Purpose: Field side: analog feedback levels and preset terminals
// Assumes: Bench sets levels in 0.1 % units
// Notes: Levels above full scale saturate like a real converter
module field_side_model (
	input wire [9:0] ain1_val,
	input wire [9:0] ain2_val,
	input wire [2:0] seg_index,
	output wire [9:0] voltage_analog_input,
	output wire [9:0] current_analog_input,
	output wire preset_select_bit0,
	output wire preset_select_bit1,
	output wire preset_select_bit2
);
	assign voltage_analog_input = ain1_val > 10'h3e8 ? 10'h3e8 : ain1_val;
	assign current_analog_input = ain2_val > 10'h3e8 ? 10'h3e8 : ain2_val;
	assign preset_select_bit0 = seg_index[0];
	assign preset_select_bit1 = seg_index[1];
	assign preset_select_bit2 = seg_index[2];
endmodule

//--- verification/process_pid_with_preset_speeds_tb_top.sv
// Purpose: Self-checking bench for the PID regulator
// Assumes: Short sample and loss units for a quick run
// Notes: Ranges allow for a few integral steps
`include "pid_regulator_defs.vh"
module process_pid_with_preset_speeds_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd, ok;
	logic [9:0] ain1 = 10'h000;
	logic [9:0] ain2 = 10'h000;
	logic [2:0] seg = 3'h0;
	wire [31:0] prdata;
	wire pready, pslverr, reverse_ff, feedback_loss_fault_ff;
	wire preset_select_bit0, preset_select_bit1, preset_select_bit2;
	wire [9:0] voltage_analog_input, current_analog_input;
	wire [15:0] freq_cmd_ff;
	int num_errors = 0;
	int num_checks = 0;
	logic [43:0] rv [9] = '{{`OFS_CTRL, 32'h0}, {`OFS_SETPOINT, 32'h0},
		{`OFS_GAIN, 32'h64}, {`OFS_ITIME, 32'ha}, {`OFS_DTIME, 32'h0},
		{`OFS_LOSS_THR, 32'h0}, {`OFS_LOSS_TIME, 32'ha},
		{`OFS_PRESET0, 32'h0}, {12'h034, 32'h0}};
	// Ctrl, ain1, ain2, dead band, gain, integral time, lowest output
	// Setpoint and feedback never share a channel
	int pr [12][7] = '{'{5, 0, 900, 0, 10000, 1000, 500},
		'{261, 0, 900, 0, 10000, 1000, 0}, '{517, 200, 200, 0, 10000, 1000, 100},
		'{4357, 0, 900, 0, 10000, 1000, 400}, '{37, 100, 600, 0, 10000, 1000, 500},
		'{277, 700, 300, 0, 10000, 1000, 400}, '{773, 0, 0, 0, 10000, 1000, 300},
		'{53, 0, 0, 0, 10000, 1000, 200}, '{69, 0, 0, 0, 10000, 1000, 300},
		'{0, 0, 0, 0, 10000, 1000, 300}, '{5, 480, 0, 50, 10000, 1000, 300},
		'{5, 0, 0, 0, 0, 1, 1000}};
	always #5 ref_clk = ~ref_clk;
	pid_regulator #(.LOSS_UNIT(32'ha), .SAMPLE_UNIT(32'h5)) i_dut (.ref_clk,
		.rst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .voltage_analog_input, .current_analog_input,
		.preset_select_bit0, .preset_select_bit1, .preset_select_bit2,
		.freq_cmd_ff, .reverse_ff, .feedback_loss_fault_ff);
	field_side_model i_field (.ain1_val(ain1), .ain2_val(ain2),
		.seg_index(seg), .voltage_analog_input, .current_analog_input,
		.preset_select_bit0, .preset_select_bit1, .preset_select_bit2);
	task check(input string name, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Called just after an edge; returns one idle edge later
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task do_reset;
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
	endtask
	task wait_check(input int n, input string name, input logic exp);
		repeat (n) @(posedge ref_clk);
		check(name, {31'h0, feedback_loss_fault_ff}, {31'h0, exp});
	endtask
	task summarize;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		do_reset();
		for (int i = 0; i < 9; i++)
		begin
			apb(1'b0, rv[i][43:32], 32'h0);
			check("reset value", rd, rv[i][31:0]);
		end
		$display("reset values done");
		for (int i = 0; i < 12; i++)
		begin
			do_reset();
			apb(1'b1, `OFS_MAXFREQ, 32'h3e8);
			apb(1'b1, `OFS_SETPOINT, 32'h1f4);
			apb(1'b1, `OFS_COMM, 32'hc8);
			apb(1'b1, `OFS_PRESET0, 32'h12c);
			apb(1'b1, `OFS_DEADBAND, 32'(pr[i][3]));
			apb(1'b1, `OFS_GAIN, 32'(pr[i][4]));
			apb(1'b1, `OFS_ITIME, 32'(pr[i][5]));
			ain1 <= 10'(pr[i][1]);
			ain2 <= 10'(pr[i][2]);
			apb(1'b1, `OFS_CTRL, 32'(pr[i][0]));
			repeat (30) @(posedge ref_clk);
			ok = {31'h0, freq_cmd_ff >= pr[i][6] && freq_cmd_ff <= pr[i][6] + 15};
			check("pid row", ok, 32'h1);
		end
		$display("pid rows done");
		// Half error step with Td equal to a 20 ms sample period
		do_reset();
		apb(1'b1, `OFS_MAXFREQ, 32'h3e8);
		apb(1'b1, `OFS_SETPOINT, 32'h1f4);
		apb(1'b1, `OFS_GAIN, 32'h0);
		apb(1'b1, `OFS_ITIME, 32'h3e8);
		apb(1'b1, `OFS_DTIME, 32'h2);
		apb(1'b1, `OFS_SAMPLE, 32'h2);
		ain1 <= 10'h000;
		apb(1'b1, `OFS_CTRL, 32'h5);
		for (int j = 0; j < 25 && freq_cmd_ff == 16'h0; j++)
			@(posedge ref_clk);
		check("derivative kick", freq_cmd_ff, 32'h1f5);
		repeat (5) @(posedge ref_clk);
		check("held between ticks", freq_cmd_ff, 32'h1f5);
		repeat (5) @(posedge ref_clk);
		check("derivative gone", freq_cmd_ff, 32'h2);
		$display("derivative done");
		do_reset();
		for (int k = 0; k < 8; k++)
			apb(1'b1, `OFS_PRESET0 + 12'(4 * k),
				32'((k == 7) ? -1000 : ((k % 2) ? -100 * k : 100 * k)));
		for (int k = 0; k < 8; k++)
		begin
			seg <= 3'(k);
			repeat (6) @(posedge ref_clk);
			apb(1'b0, `OFS_STATUS, 32'h0);
			check("preset", freq_cmd_ff, 32'((k == 7) ? 5000 : 500 * k));
			check("reverse", reverse_ff, 32'(k % 2));
			check("index", rd[4:2], 32'(k));
		end
		$display("presets done");
		do_reset();
		apb(1'b1, `OFS_LOSS_THR, 32'h64);
		apb(1'b1, `OFS_LOSS_TIME, 32'h2);
		ain1 <= 10'h064;
		apb(1'b1, `OFS_CTRL, 32'h5);
		wait_check(15, "early fault", 1'b0);
		clk_en <= 1'b0;
		wait_check(20, "frozen timer", 1'b0);
		clk_en <= 1'b1;
		wait_check(25, "fault set", 1'b1);
		ain1 <= 10'h1f4;
		wait_check(5, "sticky fault", 1'b1);
		apb(1'b1, `OFS_STATUS, 32'h1);
		wait_check(50, "fault cleared", 1'b0);
		$display("loss watch done");
		summarize();
	end
	initial
	begin
		#100us;
		num_errors++;
		$display("watchdog expired");
		summarize();
	end
endmodule
